// ==== hdl/ormm_core.sv ====
// Purpose: executes OR, move, pointer, bank and multiply instructions
// Assumes: one instruction phase per hclk; data memory answers in the read phase
// Notes:   software only starts/stops the core and observes its state
`timescale 1ns/100ps
`include "ormm_defines.svh"
module ormm_core
   import ormm_pkg::*;
#(
   parameter int NUM_PTR = 3
)
(
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // register bus
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   // program fetch
   input  wire logic [15:0] instr_word,
   input  wire logic        instr_valid,
   output logic             fetch_req,
   // data memory
   input  wire logic [7:0]  dmem_rdata,
   output ormm_dmem_t       dmem
);
   initial
   begin
      if (NUM_PTR < 1 || NUM_PTR > 3)
         $error("NUM_PTR must be 1 to 3");
   end

   logic [1:0]  q_reg;
   logic        run_reg;
   logic        second_reg;
   logic [15:0] ir_reg;
   logic [15:0] w1_reg;
   logic [7:0]  acc_reg;
   logic [7:0]  bank_reg;
   logic [15:0] prod_reg;
   logic [7:0]  opnd_reg;
   logic [7:0]  res_reg;
   logic [11:0] ptr_reg [NUM_PTR];
   ormm_flags_t flags_reg;
   ormm_dmem_t  dmem_reg;
   logic        fetch_reg;
   ormm_op_t    op;
   ormm_op_t    op1;
   logic [11:0] faddr;
   logic [7:0]  src_val;
   logic        rd_file;
   logic        last;

   assign last = run_reg && q_reg == `ORMM_LAST_PHASE;

   // decode of the word in flight; second words decode from the first
   always_comb
   begin
      op1 = OP_NOP;
      if (w1_reg[15:8] == 8'h09)
         op1 = OP_ORI;
      else if (w1_reg[15:8] == 8'h0e)
         op1 = OP_LDI;
      else if (w1_reg[15:8] == 8'h01)
         op1 = OP_BANK;
      else if (w1_reg[15:8] == 8'h0d)
         op1 = OP_MULI;
      else if (w1_reg[15:9] == 7'b0000001)
         op1 = OP_MULF;
      else if (w1_reg[15:10] == 6'b000100)
         op1 = OP_ORF;
      else if (w1_reg[15:10] == 6'b010100)
         op1 = OP_MOVREG;
      else if (w1_reg[15:9] == 7'b0110111)
         op1 = OP_STA;
      else if (w1_reg[15:8] == 8'hee && w1_reg[7:6] == 2'b00)
         op1 = OP_PTR;
      else if (w1_reg[15:12] == 4'hc)
         op1 = OP_MOVFAR;
      op = op1;
   end

   // access bank splits low ram and high special registers
   always_comb
   begin
      if (!ir_reg[8])
         faddr = {(ir_reg[7:0] < `ORMM_ACC_SPLIT) ? 4'h0 : `ORMM_ACC_HIBANK, ir_reg[7:0]};
      else
         faddr = {bank_reg[3:0], ir_reg[7:0]};
   end

   assign rd_file = op == OP_ORF || op == OP_MOVREG || op == OP_MULF || op == OP_STA;
   assign src_val = (w1_reg[11:0] == `ORMM_ACC_ADDR) ? acc_reg : dmem_rdata;

   // phase counter free-runs while enabled
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         q_reg <= 2'h0;
      else if (run_reg)
         q_reg <= q_reg + 2'h1;
   end

   // fetch: request during the last phase, latch at its end
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         fetch_reg  <= 1'b0;
         ir_reg     <= `ORMM_NOP_WORD;
         w1_reg     <= `ORMM_NOP_WORD;
         second_reg <= 1'b0;
      end
      else
      begin
         fetch_reg <= run_reg && q_reg == 2'h2;
         if (last)
         begin
            ir_reg     <= instr_valid ? instr_word : `ORMM_NOP_WORD;
            second_reg <= !second_reg && (op == OP_PTR || op == OP_MOVFAR);
            if (second_reg || (op != OP_PTR && op != OP_MOVFAR))
               w1_reg <= instr_valid ? instr_word : `ORMM_NOP_WORD;
         end
      end
   end

   // data memory strobes: address and read in Q2, write in Q4
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         dmem_reg <= '0;
      else
      begin
         dmem_reg.rd <= 1'b0;
         dmem_reg.wr <= 1'b0;
         if (run_reg && q_reg == 2'h0)
         begin
            if (op == OP_MOVFAR)
            begin
               dmem_reg.addr <= ir_reg[11:0];
               dmem_reg.rd   <= 1'b1;
            end
            else if (rd_file && !second_reg)
            begin
               dmem_reg.addr <= faddr;
               dmem_reg.rd   <= 1'b1;
            end
         end
         else if (run_reg && q_reg == 2'h2)
         begin
            if (op == OP_MOVFAR && second_reg && dmem_reg.addr != `ORMM_ACC_ADDR)
            begin
               dmem_reg.wr    <= 1'b1;
               dmem_reg.wdata <= opnd_reg;
            end
            else if (op == OP_STA && !second_reg)
            begin
               dmem_reg.wr    <= 1'b1;
               dmem_reg.wdata <= acc_reg;
            end
            else if ((op == OP_ORF || op == OP_MOVREG) && ir_reg[9] && !second_reg)
            begin
               dmem_reg.wr    <= 1'b1;
               dmem_reg.wdata <= res_reg;
            end
         end
      end
   end

   // operand and result both latched in Q2; the dummy read leaves the operand alone
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         opnd_reg <= 8'h00;
         res_reg  <= 8'h00;
      end
      else
      begin
         if (run_reg && q_reg == 2'h1 && !second_reg)
            opnd_reg <= (op == OP_MOVFAR) ? src_val : dmem_rdata;
         if (run_reg && q_reg == 2'h1)
            res_reg <= (op == OP_ORF) ? (acc_reg | dmem_rdata) : dmem_rdata;
      end
   end

   // accumulator, flags, bank and product written in Q4
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         acc_reg   <= 8'h00;
         flags_reg <= '0;
         bank_reg  <= 8'h00;
         prod_reg  <= 16'h0000;
      end
      else if (last && !second_reg)
      begin
         unique case (op)
            OP_ORI:
            begin
               acc_reg   <= acc_reg | ir_reg[7:0];
               flags_reg <= '{acc_reg[7] | ir_reg[7], (acc_reg | ir_reg[7:0]) == 8'h00};
            end
            OP_ORF, OP_MOVREG:
            begin
               if (!ir_reg[9])
                  acc_reg <= res_reg;
               flags_reg <= '{res_reg[7], res_reg == 8'h00};
            end
            OP_LDI:  acc_reg <= ir_reg[7:0];
            OP_BANK: bank_reg <= {4'h0, ir_reg[3:0]};
            OP_MULI: prod_reg <= 16'(acc_reg * ir_reg[7:0]);
            OP_MULF: prod_reg <= 16'(acc_reg * opnd_reg);
            OP_NOP, OP_PTR, OP_MOVFAR, OP_STA: ;
         endcase
      end
      else if (last && op == OP_MOVFAR && dmem_reg.addr == `ORMM_ACC_ADDR)
         acc_reg <= opnd_reg;
   end

   // indirect pointers: high nibble with first word, low byte with second
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         for (int i = 0; i < NUM_PTR; i++)
            ptr_reg[i] <= 12'h000;
      end
      else if (last && op == OP_PTR)
      begin
         for (int i = 0; i < NUM_PTR; i++)
         begin
            if (w1_reg[5:4] == 2'(i) && !second_reg)
               ptr_reg[i][11:8] <= w1_reg[3:0];
            else if (w1_reg[5:4] == 2'(i))
               ptr_reg[i][7:0] <= ir_reg[7:0];
         end
      end
   end

   // ahb-lite slave: zero wait states, always OKAY, unmapped reads zero
   logic        dphase_wr_reg;
   logic [7:0]  dphase_addr_reg;
   logic [31:0] rd_val;
   always_comb
   begin
      rd_val = 32'h0000_0000;
      if (haddr[7:0] == `ORMM_OFF_CTRL)
         rd_val = {31'h0, run_reg};
      else if (haddr[7:0] == `ORMM_OFF_ACC)
         rd_val = {24'h0, acc_reg};
      else if (haddr[7:0] == `ORMM_OFF_BANK)
         rd_val = {24'h0, bank_reg};
      else if (haddr[7:0] == `ORMM_OFF_FLAGS)
         rd_val = {30'h0, flags_reg};
      else if (haddr[7:0] == `ORMM_OFF_PROD)
         rd_val = {16'h0, prod_reg};
      else if (haddr[7:0] == `ORMM_OFF_STATE)
         rd_val = {29'h0, second_reg, q_reg};
      for (int i = 0; i < NUM_PTR; i++)
         if (haddr[7:0] == 8'(`ORMM_OFF_PTR0 + 4 * i))
            rd_val = {20'h0, ptr_reg[i]};
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dphase_wr_reg   <= 1'b0;
         dphase_addr_reg <= 8'h00;
         hrdata          <= 32'h0000_0000;
      end
      else
      begin
         dphase_wr_reg <= hsel && hready && htrans[1] && hwrite && hsize == 3'h2;
         if (hsel && hready && htrans[1])
         begin
            dphase_addr_reg <= haddr[7:0];
            hrdata          <= hwrite ? 32'h0000_0000 : rd_val;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         run_reg <= 1'b0;
      else if (dphase_wr_reg && dphase_addr_reg == `ORMM_OFF_CTRL)
         run_reg <= hwdata[`ORMM_CTRL_RUN];
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hreadyout <= 1'b0;
         hresp     <= 1'b0;
      end
      else
         hreadyout <= 1'b1;
   end

   assign fetch_req = fetch_reg;
   assign dmem      = dmem_reg;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_exec_last(ormm_op_t o);
      last && !second_reg && op == o;
   endsequence
   sequence s_far_second;
      run_reg && q_reg == 2'h2 && op == OP_MOVFAR && second_reg;
   endsequence

   a_phase_order: assert property (run_reg && q_reg == 2'h3 |=> q_reg == 2'h0)
      else $error("phase did not wrap");
   a_or_imm_acc: assert property (s_exec_last(OP_ORI) |=>
      acc_reg == ($past(acc_reg) | $past(ir_reg[7:0])) && flags_reg.zero == (acc_reg == 8'h00))
      else $error("or immediate wrong");
   a_load_imm_acc: assert property (s_exec_last(OP_LDI) |=>
      acc_reg == $past(ir_reg[7:0]) && flags_reg == $past(flags_reg))
      else $error("load immediate wrong");
   a_bank_low_nibble: assert property (s_exec_last(OP_BANK) |=>
      bank_reg == {4'h0, $past(ir_reg[3:0])} && $stable(flags_reg))
      else $error("bank load wrong");
   a_mul_imm_prod: assert property (s_exec_last(OP_MULI) |=>
      prod_reg == $past(acc_reg) * $past(ir_reg[7:0]) && $stable(acc_reg))
      else $error("multiply immediate wrong");
   a_mul_reg_keep: assert property (s_exec_last(OP_MULF) |=>
      $stable(acc_reg) && $stable(flags_reg) && !dmem_reg.wr)
      else $error("multiply register altered state");
   a_access_bank_sel: assert property (run_reg && q_reg == 2'h0 && rd_file && !ir_reg[8]
      && !second_reg |=> dmem_reg.rd && (dmem_reg.addr[11:8] == 4'h0
      || dmem_reg.addr[11:8] == 4'hf))
      else $error("access bank address wrong");
   a_far_move_wr: assert property ((s_far_second and (dmem_reg.addr != `ORMM_ACC_ADDR))
      |=> dmem_reg.wr && dmem_reg.wdata == $past(opnd_reg) ##1 !dmem_reg.wr)
      else $error("move write missing");
   a_store_acc_wr: assert property (run_reg && q_reg == 2'h2 && op == OP_STA && !second_reg
      |=> dmem_reg.wr && dmem_reg.wdata == acc_reg && $stable(flags_reg))
      else $error("store accumulator wrong");
endmodule

// ==== hdl/ormm_defines.svh ====
// Purpose: constants of the instruction block and its register window
// Assumes: included by bare name
// Notes:   byte addresses on a 32-bit bus
`ifndef ORMM_DEFINES_SVH
`define ORMM_DEFINES_SVH
`define ORMM_OFF_CTRL   8'h00
`define ORMM_OFF_ACC    8'h04
`define ORMM_OFF_BANK   8'h08
`define ORMM_OFF_FLAGS  8'h0c
`define ORMM_OFF_PROD   8'h10
`define ORMM_OFF_PTR0   8'h14
`define ORMM_OFF_STATE  8'h20
`define ORMM_CTRL_RUN   0
`define ORMM_ACC_ADDR   12'hfe8
`define ORMM_ACC_SPLIT  8'h80
`define ORMM_ACC_HIBANK 4'hf
`define ORMM_PFX_SECOND 4'hf
`define ORMM_NOP_WORD   16'h0000
`define ORMM_LAST_PHASE 2'h3
`endif

// ==== hdl/ormm_pkg.sv ====
// Purpose: types shared by the instruction block
// Assumes: nothing
// Notes:   op codes are internal, not instruction encodings
package ormm_pkg;
   typedef enum logic [3:0]
   {
      OP_NOP    = 4'h0,
      OP_ORI    = 4'h1,
      OP_ORF    = 4'h2,
      OP_PTR    = 4'h3,
      OP_MOVREG = 4'h4,
      OP_MOVFAR = 4'h5,
      OP_BANK   = 4'h6,
      OP_LDI    = 4'h7,
      OP_STA    = 4'h8,
      OP_MULI   = 4'h9,
      OP_MULF   = 4'ha
   } ormm_op_t;
   typedef struct packed
   {
      logic [11:0] addr;
      logic        rd;
      logic        wr;
      logic [7:0]  wdata;
   } ormm_dmem_t;
   typedef struct packed
   {
      logic neg;
      logic zero;
   } ormm_flags_t;
endpackage

// ==== testbench/ormm_far_model.sv ====
// Purpose: program fetch path and 4 KB data memory facing the core
// Assumes: program words loaded into prog before the core is started
// Notes:   undriven read data shows the inverse so stale bytes never pass
`timescale 1ns/100ps
module ormm_far_model
   import ormm_pkg::*;
(
   // clock and reset
   input  wire logic       hclk,
   input  wire logic       hresetn,
   // fetch path
   input  wire logic       fetch_req,
   output logic [15:0]     instr_word,
   output logic            instr_valid,
   // data memory
   input  wire ormm_dmem_t dmem,
   output logic [7:0]      dmem_rdata
);
   logic [7:0]  mem [0:4095];
   logic [15:0] prog [0:15];
   logic [4:0]  pc;
   logic [4:0]  plen;
   logic        rd_d;

   assign instr_valid = fetch_req && (pc < plen);
   assign instr_word  = instr_valid ? prog[pc[3:0]] : ~prog[0];
   // rd_d keeps the byte up through the cycle after the strobe
   assign dmem_rdata  = (dmem.rd || rd_d) ? mem[dmem.addr] : ~mem[dmem.addr];

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pc   <= 5'h00;
         rd_d <= 1'b0;
      end
      else
      begin
         rd_d <= dmem.rd;
         if (instr_valid)
            pc <= pc + 5'h01;
         if (dmem.wr)
            mem[dmem.addr] <= dmem.wdata;
      end
   end
endmodule

// ==== testbench/or_move_multiply_instructions_test.sv ====
// Purpose: random and corner programs through the core, checked over the bus and in the data memory model
// Assumes: zero-wait bus slave; accumulator at fe8 is internal to the core
// Notes:   each round restarts from reset, which also exercises re-reset
`timescale 1ns/100ps
module or_move_multiply_instructions_test;
   import ormm_pkg::*;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hready;
   logic [31:0] hrdata;
   logic        hresp;
   logic [15:0] instr_word;
   logic        instr_valid;
   logic        fetch_req;
   logic [7:0]  dmem_rdata;
   ormm_dmem_t  dmem;
   int          num_errors;
   int          compares;
   int          cyc;
   int          seed;
   logic [7:0]  k1, k2, k3, m, m2, a, f;
   logic [11:0] kp;
   logic [31:0] v;

   ormm_core DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
      .instr_word(instr_word), .instr_valid(instr_valid), .fetch_req(fetch_req),
      .dmem_rdata(dmem_rdata), .dmem(dmem));
   ormm_far_model u_far (.hclk(hclk), .hresetn(hresetn), .fetch_req(fetch_req),
      .instr_word(instr_word), .instr_valid(instr_valid), .dmem(dmem),
      .dmem_rdata(dmem_rdata));

   always #10 hclk = ~hclk;

   task automatic close_out();
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // hang guard, far above four rounds of some 110 cycles each
   always @(posedge hclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         num_errors++;
         close_out();
      end
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // one single word transfer; read data taken at the edge ending the data phase
   task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] wd,
                      output logic [31:0] rd);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {24'h000000, ad};
      hwrite <= wr;
      hsize  <= 3'h2;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask

   function automatic logic [31:0] nz(input logic [7:0] x);
      return {30'h0, x[7], x == 8'h00};
   endfunction

   initial
   begin
      hclk = 1'b0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      num_errors = 0;
      compares = 0;
      cyc = 0;
      seed = 90;
      for (int r = 0; r < 4; r++)
      begin
         k1 = $random(seed);
         k2 = $random(seed);
         k3 = $random(seed);
         m  = $random(seed);
         m2 = $random(seed);
         kp = $random(seed);
         if (r == 0)
         begin
            k1 = 8'h00;
            k2 = 8'h00;
            m  = 8'h00;
         end
         if (r == 1)
            k2 = k2 | 8'h80;
         a = k1 | k2;
         f = a | m;
         hresetn <= 1'b0;
         repeat (20) @(posedge hclk);
         hresetn <= 1'b1;
         repeat (2) @(posedge hclk);
         u_far.mem[12'h533] = m;
         u_far.mem[12'h534] = m2;
         // no move below names the program counter or stack bytes as target
         u_far.prog[0]  = {8'h0e, k1};
         u_far.prog[1]  = {8'h09, k2};
         u_far.prog[2]  = 16'h0105;
         u_far.prog[3]  = 16'h6f10;
         u_far.prog[4]  = 16'h6e90;
         u_far.prog[5]  = 16'hc510;
         u_far.prog[6]  = 16'hf123;
         u_far.prog[7]  = {12'hee1, kp[11:8]};
         u_far.prog[8]  = {8'hf0, kp[7:0]};
         u_far.prog[9]  = 16'h1333;
         u_far.prog[10] = 16'h5133;
         u_far.prog[11] = r[0] ? 16'h0334 : {8'h0d, k3};
         // odd pairs of rounds move a byte into the accumulator, no flags touched
         u_far.prog[12] = r[1] ? 16'hc534 : 16'h0000;
         u_far.prog[13] = r[1] ? 16'hffe8 : 16'h0000;
         u_far.plen = 5'd14;
         bus(1'b1, 8'h00, 32'h1, v);
         for (int n = 0; n < 300 && u_far.pc != 5'd14; n++)
            @(posedge hclk);
         repeat (8) @(posedge hclk);
         bus(1'b0, 8'h04, 32'h0, v);
         chk("acc", v, {24'h0, r[1] ? m2 : f});
         bus(1'b0, 8'h0c, 32'h0, v);
         chk("flags", v, nz(f));
         bus(1'b0, 8'h08, 32'h0, v);
         chk("bank", v, 32'h5);
         bus(1'b0, 8'h10, 32'h0, v);
         chk("product", v, {16'h0, 16'(f) * 16'(r[0] ? m2 : k3)});
         bus(1'b0, 8'h18, 32'h0, v);
         chk("pointer", v, {20'h0, kp});
         chk("bank store", {24'h0, u_far.mem[12'h510]}, {24'h0, a});
         chk("access store", {24'h0, u_far.mem[12'hf90]}, {24'h0, a});
         chk("far move", {24'h0, u_far.mem[12'h123]}, {24'h0, a});
         chk("or to file", {24'h0, u_far.mem[12'h533]}, {24'h0, f});
         chk("mul operand", {24'h0, u_far.mem[12'h534]}, {24'h0, m2});
         bus(1'b1, 8'h04, 32'h5a, v);
         bus(1'b0, 8'h04, 32'h0, v);
         chk("acc read only", v, {24'h0, r[1] ? m2 : f});
         bus(1'b0, 8'h40, 32'h0, v);
         chk("unmapped", v, 32'h0);
         bus(1'b0, 8'h00, 32'h0, v);
         chk("ctrl", v, 32'h1);
         $display("round %0d done", r);
      end
      close_out();
   end
endmodule
